// ---- verilog/apd_map.vh ----
`ifndef APD_MAP_VH
`define APD_MAP_VH
// ****************************************
// register offsets (word addresses)
// ****************************************
`define OFS_MODE_A        2'h0
`define OFS_MODE_B        2'h1
`define OFS_STATUS        2'h2
// ****************************************
// power mode reg a fields
// ****************************************
`define A_APD_EN          1
`define A_TURBO_OFF       3
`define A_ARRAY_CLK_OFF   4
`define A_MCELL_CLK_OFF   5
`define A_WMASK           8'h3A
// ****************************************
// power mode reg b fields
// ****************************************
`define B_CNTL0_OFF       2
`define B_CNTL1_OFF       3
`define B_CNTL2_OFF       4
`define B_STROBE_OFF      5
`define B_DBE_OFF         6
`define B_WMASK           8'h7C
// ****************************************
// reset values and timing
// ****************************************
`define MODE_RESET        8'h00
`define IDLE_LIMIT        4'hF
`define READ_ZERO         32'h00000000
`endif

// ---- verilog/apd_idle_counter.v ----
`timescale 1ns/100ps
// ****************************************
// four bit idle counter with sticky flag
// ****************************************
module apd_idle_counter (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       enable_i,
   input  wire       activity_i,
   input  wire       wake_i,
   output reg        flag_o
);
`include "apd_map.vh"
   reg  [3:0] count_r;
   reg  [3:0] count_nxt;
   reg        flag_nxt;

   always @* begin
      count_nxt = count_r;
      flag_nxt  = flag_o;
      if (!enable_i || activity_i || wake_i) begin
         count_nxt = 4'h0;
         flag_nxt  = 1'b0;
      end else if (count_r != `IDLE_LIMIT) begin
         count_nxt = count_r + 4'h1;
         if (count_r == `IDLE_LIMIT - 4'h1) begin
            flag_nxt = 1'b1;
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_r <= 4'h0;
         flag_o  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         flag_o  <= flag_nxt;
      end
   end
endmodule

// ---- verilog/auto_powerdown_unit.v ----
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/100ps
module auto_powerdown_unit (
   input  wire        REF_CLK_I,
   input  wire        RESET_N_I,
   input  wire        POWER_UP_N_I,
   input  wire        DEVICE_RESET_I,
   input  wire [1:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   output reg  [31:0] AVS_READDATA_O,
   output reg         AVS_WAITREQUEST_O,
   input  wire        ADDRESS_STROBE_I,
   input  wire        DEVICE_SELECT_N_I,
   input  wire        CNTL0_I,
   input  wire        CNTL1_I,
   input  wire        CNTL2_I,
   input  wire        DBE_I,
   input  wire [7:0]  MCU_BUS_I,
   output reg         POWERDOWN_FLAG_O,
   output reg  [7:0]  MEM_BUS_O,
   output reg  [7:0]  ARRAY_BUS_O,
   output reg         MEM_SELECT_O,
   output reg         ARRAY_CLK_EN_O,
   output reg         MCELL_CLK_EN_O,
   output reg         TURBO_OFF_O,
   output reg         CNTL0_O,
   output reg         CNTL1_O,
   output reg         CNTL2_O,
   output reg         STROBE_O,
   output reg         DBE_O,
   output reg         DATA_PORT_OE_O,
   output reg         PERIPH_OE_O
);
`include "apd_map.vh"
   // ****************************************
   // input synchronisers
   // ****************************************
   reg  [6:0] sync1_r;
   reg  [6:0] sync2_r;
   reg        strobe_d_r;
   reg  [7:0] bus_s1_r;
   reg  [7:0] bus_s2_r;
   wire       strobe_s   = sync2_r[0];
   wire       sel_n_s    = sync2_r[1];
   wire       dreset_s   = sync2_r[6];

   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         sync1_r    <= 7'h02;
         sync2_r    <= 7'h02;
         strobe_d_r <= 1'b0;
         bus_s1_r   <= 8'h00;
         bus_s2_r   <= 8'h00;
      end else begin
         sync1_r    <= {DEVICE_RESET_I, DBE_I, CNTL2_I, CNTL1_I, CNTL0_I,
                        DEVICE_SELECT_N_I, ADDRESS_STROBE_I};
         sync2_r    <= sync1_r;
         strobe_d_r <= strobe_s;
         bus_s1_r   <= MCU_BUS_I;
         bus_s2_r   <= bus_s1_r;
      end
   end

   // ****************************************
   // mode registers, cleared at power-up only
   // ****************************************
   reg  [7:0] mode_a_r;
   reg  [7:0] mode_b_r;
   wire       wr_a = AVS_WRITE_I && !AVS_WAITREQUEST_O &&
                     (AVS_ADDRESS_I == `OFS_MODE_A) && AVS_BYTEENABLE_I[0];
   wire       wr_b = AVS_WRITE_I && !AVS_WAITREQUEST_O &&
                     (AVS_ADDRESS_I == `OFS_MODE_B) && AVS_BYTEENABLE_I[0];

   always @(posedge REF_CLK_I or negedge POWER_UP_N_I) begin
      if (!POWER_UP_N_I) begin
         mode_a_r <= `MODE_RESET;
         mode_b_r <= `MODE_RESET;
      end else begin
         if (wr_a) begin
            mode_a_r <= AVS_WRITEDATA_I[7:0] & `A_WMASK;
         end
         if (wr_b) begin
            mode_b_r <= AVS_WRITEDATA_I[7:0] & `B_WMASK;
         end
      end
   end

   // ****************************************
   // idle counter, always on the unblocked clock
   // ****************************************
   wire       activity = strobe_s ^ strobe_d_r;
   wire       wake     = !sel_n_s || dreset_s;
   wire       pd_flag;

   apd_idle_counter u_idle (
      .clk_i      (REF_CLK_I),
      .rst_n_i    (RESET_N_I),
      .enable_i   (mode_a_r[`A_APD_EN]),
      .activity_i (activity),
      .wake_i     (wake),
      .flag_o     (pd_flag)
   );

   // ****************************************
   // bus slave: one wait state per access
   // ****************************************
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O    <= `READ_ZERO;
      end else begin
         AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
         if (AVS_READ_I && AVS_WAITREQUEST_O) begin
            case (AVS_ADDRESS_I)
               `OFS_MODE_A: begin
                  AVS_READDATA_O <= {24'h000000, mode_a_r};
               end
               `OFS_MODE_B: begin
                  AVS_READDATA_O <= {24'h000000, mode_b_r};
               end
               `OFS_STATUS: begin
                  AVS_READDATA_O <= {30'h00000000, sel_n_s, pd_flag};
               end
               default: begin
                  AVS_READDATA_O <= `READ_ZERO;
               end
            endcase
         end
      end
   end

   // ****************************************
   // outputs to memories, arrays and ports
   // ****************************************
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         POWERDOWN_FLAG_O <= 1'b0;
         MEM_BUS_O        <= 8'h00;
         ARRAY_BUS_O      <= 8'h00;
         MEM_SELECT_O     <= 1'b0;
         ARRAY_CLK_EN_O   <= 1'b1;
         MCELL_CLK_EN_O   <= 1'b1;
         TURBO_OFF_O      <= 1'b0;
         CNTL0_O          <= 1'b0;
         CNTL1_O          <= 1'b0;
         CNTL2_O          <= 1'b0;
         STROBE_O         <= 1'b0;
         DBE_O            <= 1'b0;
         DATA_PORT_OE_O   <= 1'b0;
         PERIPH_OE_O      <= 1'b0;
      end else begin
         POWERDOWN_FLAG_O <= pd_flag;
         if (!pd_flag) begin
            MEM_BUS_O   <= bus_s2_r;
            ARRAY_BUS_O <= bus_s2_r;
         end
         MEM_SELECT_O   <= !pd_flag && !sel_n_s;
         ARRAY_CLK_EN_O <= !mode_a_r[`A_ARRAY_CLK_OFF];
         MCELL_CLK_EN_O <= !mode_a_r[`A_MCELL_CLK_OFF];
         TURBO_OFF_O    <= mode_a_r[`A_TURBO_OFF];
         CNTL0_O  <= sync2_r[2] & !mode_b_r[`B_CNTL0_OFF];
         CNTL1_O  <= sync2_r[3] & !mode_b_r[`B_CNTL1_OFF];
         CNTL2_O  <= sync2_r[4] & !mode_b_r[`B_CNTL2_OFF];
         STROBE_O <= strobe_s & !mode_b_r[`B_STROBE_OFF];
         DBE_O    <= sync2_r[5] & !mode_b_r[`B_DBE_OFF];
         DATA_PORT_OE_O <= !pd_flag && !sel_n_s;
         PERIPH_OE_O    <= !pd_flag && !sel_n_s;
      end
   end
endmodule

// ---- verif/apd_chk.sv ----
`timescale 1ns/100ps
// ****
// port checks
// ****
module apd_chk (
   input wire       REF_CLK_I,
   input wire       RESET_N_I,
   input wire       AVS_READ_I,
   input wire       AVS_WRITE_I,
   input wire       AVS_WAITREQUEST_O,
   input wire       ADDRESS_STROBE_I,
   input wire       DEVICE_SELECT_N_I,
   input wire       DEVICE_RESET_I,
   input wire       POWERDOWN_FLAG_O,
   input wire       MEM_SELECT_O,
   input wire [7:0] MEM_BUS_O,
   input wire [7:0] ARRAY_BUS_O,
   input wire       DATA_PORT_OE_O,
   input wire       PERIPH_OE_O
);
   reg [4:0] idle_r;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) idle_r <= 5'h00;
      else if ($changed(ADDRESS_STROBE_I)) idle_r <= 5'h00;
      else if (idle_r != 5'h1F) idle_r <= idle_r + 5'h01;
   end
   idle_span_a: assert property ($rose(POWERDOWN_FLAG_O) |-> idle_r >= 5'h0F)
      else $error("power-down too early");
   strobe_wake_a: assert property ($changed(ADDRESS_STROBE_I) |-> ##[1:6] !POWERDOWN_FLAG_O)
      else $error("no wake on strobe");
   select_wake_a: assert property (!DEVICE_SELECT_N_I [*6] |-> !POWERDOWN_FLAG_O)
      else $error("no wake on select");
   reset_wake_a: assert property (DEVICE_RESET_I [*6] |-> !POWERDOWN_FLAG_O)
      else $error("no wake on reset");
   mem_desel_a: assert property (POWERDOWN_FLAG_O |-> !MEM_SELECT_O)
      else $error("memory selected in power-down");
   select_off_a: assert property (DEVICE_SELECT_N_I [*5] |-> !MEM_SELECT_O)
      else $error("memory selected while deselected");
   port_tri_a: assert property (POWERDOWN_FLAG_O |-> !DATA_PORT_OE_O && !PERIPH_OE_O)
      else $error("port driven in power-down");
   bus_hold_a: assert property (POWERDOWN_FLAG_O && $past(POWERDOWN_FLAG_O)
      |-> $stable(MEM_BUS_O) && $stable(ARRAY_BUS_O))
      else $error("bus not blocked");
   bus_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
      |-> ##[1:2] !AVS_WAITREQUEST_O)
      else $error("no bus answer");
   cover property ($rose(POWERDOWN_FLAG_O));
   cover property ($fell(POWERDOWN_FLAG_O) && !DEVICE_SELECT_N_I);
   cover property ($fell(POWERDOWN_FLAG_O) && DEVICE_RESET_I);
endmodule
bind auto_powerdown_unit apd_chk i_apd_chk (.*);

// ---- verif/mcu_model.sv ----
`timescale 1ns/100ps
// ****
// mcu strobe and bus source
// ****
module mcu_model (
   input  wire       clk_i,
   input  wire       run_i,
   output reg        strobe_o,
   output reg  [7:0] bus_o
);
   reg [1:0] div_r;
   initial begin
      strobe_o = 1'b0;
      bus_o = 8'h00;
      div_r = 2'h0;
   end
   always @(posedge clk_i) begin
      div_r <= div_r + 2'h1;
      bus_o <= bus_o + 8'h01;
      if (run_i && div_r == 2'h3) strobe_o <= ~strobe_o;
   end
endmodule

// ---- verif/auto_powerdown_unit_tb_top.sv ----
`timescale 1ns/100ps
module auto_powerdown_unit_tb_top;
   reg         clk, rst_n, pup_n, dev_rst, sel_n, run, rd, wr;
   reg  [1:0]  adr;
   reg  [31:0] wdat, got;
   reg  [3:0]  ctl;
   wire [31:0] rdat;
   wire        wait_o, strobe, pd, msel, ace, mce, turbo, c0, c1, c2, so, dbo, doe, poe;
   wire [7:0]  mbus, mem_b, arr_b;
   integer     bad_count, cmp_count, cyc, n;
   mcu_model i_mcu_model (.clk_i(clk), .run_i(run), .strobe_o(strobe), .bus_o(mbus));
   auto_powerdown_unit i_auto_powerdown_unit (.REF_CLK_I(clk), .RESET_N_I(rst_n),
      .POWER_UP_N_I(pup_n), .DEVICE_RESET_I(dev_rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wait_o), .ADDRESS_STROBE_I(strobe), .DEVICE_SELECT_N_I(sel_n),
      .CNTL0_I(ctl[0]), .CNTL1_I(ctl[1]), .CNTL2_I(ctl[2]), .DBE_I(ctl[3]), .MCU_BUS_I(mbus),
      .POWERDOWN_FLAG_O(pd), .MEM_BUS_O(mem_b), .ARRAY_BUS_O(arr_b), .MEM_SELECT_O(msel),
      .ARRAY_CLK_EN_O(ace), .MCELL_CLK_EN_O(mce), .TURBO_OFF_O(turbo), .CNTL0_O(c0),
      .CNTL1_O(c1), .CNTL2_O(c2), .STROBE_O(so), .DBE_O(dbo), .DATA_PORT_OE_O(doe),
      .PERIPH_OE_O(poe));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task final_report;
      begin
         $display("counts bad %0d cmp %0d", bad_count, cmp_count);
         if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task acc(input w, input [1:0] a, input [31:0] d);
      begin
         @(posedge clk);
         rd <= !w;
         wr <= w;
         adr <= a;
         wdat <= d;
         @(posedge clk);
         while (wait_o !== 1'b0) @(posedge clk);
         got = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task wt(input v);
      begin
         n = 0;
         while (pd !== v) begin
            @(posedge clk);
            n = n + 1;
         end
      end
   endtask
   initial begin
      bad_count = 0; cmp_count = 0; cyc = 0; rst_n = 0; pup_n = 0; dev_rst = 0;
      sel_n = 1; run = 1; rd = 0; wr = 0; adr = 0; wdat = 0; ctl = 4'hF;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      pup_n <= 1'b1;
      acc(0, 2'h0, 0); chk("mode_a", 32'h00, got);
      acc(0, 2'h1, 0); chk("mode_b", 32'h00, got);
      chk("turbo", 0, turbo);
      chk("clk_on", 3, {ace, mce});
      acc(1, 2'h0, 32'hFF); acc(0, 2'h0, 0); chk("mode_a", 32'h3A, got);
      chk("clk_en", 0, {ace, mce});
      chk("turbo", 1, turbo);
      acc(1, 2'h1, 32'hFF); acc(0, 2'h1, 0); chk("mode_b", 32'h7C, got);
      repeat (4) @(posedge clk);
      chk("blocked", 0, {c0, c1, c2, so, dbo});
      acc(0, 2'h3, 0); chk("unmapped", 0, got);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      acc(0, 2'h0, 0); chk("keep_a", 32'h3A, got);
      acc(1, 2'h1, 0);
      $display("register test done");
      run <= 1'b0;
      wt(1); chk("pd_time", 1, n >= 12 && n <= 21);
      chk("msel", 0, msel);
      chk("oe", 0, {doe, poe});
      acc(0, 2'h2, 0); chk("status", 32'h3, got);
      got = {16'h0, mem_b, arr_b};
      repeat (5) @(posedge clk);
      chk("frozen", got, {mem_b, arr_b});
      chk("arr_on", 4'hF, {c0, c1, c2, dbo});
      ctl <= 4'h0;
      repeat (4) @(posedge clk);
      chk("arr_live", 0, {c0, c1, c2, dbo});
      run <= 1'b1;
      @(strobe);
      wt(0); chk("wake_strb", 1, n <= 5);
      chk("bus_live", 1, mem_b !== got[15:8] && arr_b !== got[7:0]);
      run <= 1'b0;
      wt(1);
      sel_n <= 1'b0;
      wt(0); chk("wake_sel", 1, n <= 6);
      repeat (3) @(posedge clk);
      chk("msel_on", 1, msel);
      sel_n <= 1'b1;
      wt(1);
      dev_rst <= 1'b1;
      wt(0); chk("wake_rst", 1, n <= 6);
      $display("power-down test done");
      acc(1, 2'h0, 0);
      dev_rst <= 1'b0;
      repeat (40) @(posedge clk);
      chk("no_pd", 0, pd);
      acc(1, 2'h0, 32'h02);
      wt(1); chk("pd_on", 1, n >= 15 && n <= 18);
      $display("enable test done");
      final_report;
   end
endmodule
